// *** design/ldm_mux_dimmer.sv ***
// timer-driven display multiplexer with compare-based dimming
//
// Summary of operation
// (R1) drives three seven-segment digits (leading uses four segments) plus ten leds
// (R2) four-position scan, one digit select high at a time in fixed order
// (R3) segment outputs hold the pattern of the active position
// (R4) multiplex timer auto-reloads and counts at oscillator divided by twelve
// (R5) each overflow reloads the timer with ff00
// (R6) 256 increments of 2 us between overflows, 512 us period
// (R7) timer base equals 6 MHz oscillator machine cycle of 2 us
// (R8) each multiplex step lasts exactly one overflow interval
// (R9) overflow event outputs next pattern and its digit select
// (R10) timer equal to compare value raises a separate event in the step
// (R11) compare event drives all selects low until next overflow
// (R12) compare value may change at any time without synchronising
// (R13) compare value comes from ambient light via a rom table
// (R14) compare outside reload..max gives no match, full brightness
// (R15) after fourth position scan wraps to the first
`timescale 1ns/1ps
`default_nettype none
module ldm_mux_dimmer #(
    parameter int unsigned TICK_CYCLES = ldm_pkg::TICK_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] digit0_seg,
    input wire logic [ldm_pkg::SEG_W-1:0] digit1_seg,
    input wire logic [ldm_pkg::SEG_W-1:0] digit2_seg,
    input wire logic [ldm_pkg::NUM_LEDS-1:0] led_on,
    input wire logic [ldm_pkg::LIGHT_W-1:0] ambient_light,
    output logic [ldm_pkg::SEG_W-1:0] segment_outputs,
    output logic [ldm_pkg::NUM_POS-1:0] digit_select_outputs,
    output logic overflow_evt,
    output logic compare_evt
);
    // ----------------------------------------------------------------
    // time base and timer
    // ----------------------------------------------------------------
    logic [ldm_pkg::TICK_W-1:0] div_ff;
    logic tick;
    logic [15:0] tmr_ff;
    logic [15:0] cmp_ff;
    logic [1:0] pos_ff;
    logic [ldm_pkg::SEG_W-1:0] nxt_seg;
    logic [1:0] nxt_pos;
    logic ovf;
    logic match;

    // one-cycle enable every machine cycle: 80 core clocks = 2 us
    assign tick = (div_ff == ldm_pkg::TICK_W'(TICK_CYCLES - 1)); // R4 R7
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            div_ff <= '0;
        else if (tick)
            div_ff <= '0;
        else
            div_ff <= div_ff + 1'b1;
    end

    assign ovf = tick && (tmr_ff == ldm_pkg::TMR_MAX);
    // compare value is a plain register so it can be rewritten anytime; match
    // on an out-of-window value never occurs so brightness is then full
    assign match = tick && (tmr_ff + 16'h0001 == cmp_ff) && !ovf // R10 R14
                   && (cmp_ff > ldm_pkg::RELOAD_VAL);

    // auto-reload timer: ff00..ffff, 256 counts of 2 us = 512 us
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tmr_ff <= ldm_pkg::RELOAD_VAL;
        else if (ovf)
            tmr_ff <= ldm_pkg::RELOAD_VAL; // R5 R6
        else if (tick)
            tmr_ff <= tmr_ff + 16'h0001; // R4
    end

    // ----------------------------------------------------------------
    // brightness lookup
    // ----------------------------------------------------------------
    // rom: darker surroundings give an earlier compare, i.e. a dimmer display
    function automatic logic [15:0] light_rom(input logic [ldm_pkg::LIGHT_W-1:0] l);
        logic [15:0] v;
        v = ldm_pkg::RELOAD_VAL + {8'h00, l, 4'h0} + 16'h0010;
        if (l == '1)
            v = 16'h0000; // brightest: out of window, no match
        return v;
    endfunction

    // resampled every cycle; no alignment with the scan is needed
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cmp_ff <= 16'h0000;
        else
            cmp_ff <= light_rom(ambient_light); // R12 R13
    end

    // ----------------------------------------------------------------
    // scan sequencer
    // ----------------------------------------------------------------
    assign nxt_pos = (pos_ff == ldm_pkg::POS_LAST) ? 2'h0 : pos_ff + 2'h1; // R15

    // position 0: four-segment lead digit, 3: indicator leds (7 per step
    // would not fit ten leds, so leds 7..9 share the lead digit's spare lines)
    always_comb
    begin
        case (nxt_pos)
            2'h0: nxt_seg = {led_on[9:7], digit0_seg}; // R1
            2'h1: nxt_seg = digit1_seg;
            2'h2: nxt_seg = digit2_seg;
            default: nxt_seg = led_on[6:0];
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pos_ff <= ldm_pkg::POS_LAST;
        else if (ovf)
            pos_ff <= nxt_pos; // R2 R8
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            segment_outputs <= '0;
        else if (ovf)
            segment_outputs <= nxt_seg; // R3 R9
    end

    // compare blanks all selects; overflow re-enables the new position
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            digit_select_outputs <= ldm_pkg::SEL_NONE;
        else if (ovf)
            digit_select_outputs <= ldm_pkg::SEL_FIRST << nxt_pos; // R2 R9
        else if (match)
            digit_select_outputs <= ldm_pkg::SEL_NONE; // R11
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overflow_evt <= 1'b0;
            compare_evt <= 1'b0;
        end
        else
        begin
            overflow_evt <= ovf; // R9
            compare_evt <= match; // R10
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // one step in core clocks; a counter stands in for a long delay range
    localparam logic [15:0] STEP_CYC =
        16'(TICK_CYCLES * (ldm_pkg::TMR_MAX - ldm_pkg::RELOAD_VAL + 1));
    logic [15:0] step_cnt_ff;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            step_cnt_ff <= '0;
        else if (overflow_evt)
            step_cnt_ff <= 16'h0001;
        else
            step_cnt_ff <= step_cnt_ff + 16'h0001;
    end

    sequence s_ovf;
        overflow_evt;
    endsequence
    sequence s_cmp;
        compare_evt;
    endsequence

    property p_onehot;
        @(posedge clock) disable iff (!rst_n) $onehot0(digit_select_outputs);
    endproperty
    a_onehot: assert property (p_onehot) else $error("select not one-hot"); // R2
    property p_wrap;
        @(posedge clock) disable iff (!rst_n)
            s_ovf ##0 ($past(pos_ff) == ldm_pkg::POS_LAST)
            |-> digit_select_outputs == ldm_pkg::SEL_FIRST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("scan did not wrap"); // R15
    property p_period;
        @(posedge clock) disable iff (!rst_n)
            s_ovf ##0 (step_cnt_ff != 16'h0000) |-> step_cnt_ff == STEP_CYC;
    endproperty
    a_period: assert property (p_period) else $error("step not 512 us"); // R6 R8
    property p_blank;
        @(posedge clock) disable iff (!rst_n)
            s_cmp |-> digit_select_outputs == 4'h0;
    endproperty
    a_blank: assert property (p_blank) else $error("compare did not blank"); // R11
    property p_stay;
        @(posedge clock) disable iff (!rst_n)
            digit_select_outputs == 4'h0 && !overflow_evt ##1 !overflow_evt
            |-> digit_select_outputs == 4'h0 || !rst_n;
    endproperty
    a_stay: assert property (p_stay) else $error("select rose early"); // R11
    property p_sel;
        @(posedge clock) disable iff (!rst_n)
            s_ovf |-> digit_select_outputs == (4'h1 << pos_ff);
    endproperty
    a_sel: assert property (p_sel) else $error("wrong select"); // R9
    property p_seg;
        @(posedge clock) disable iff (!rst_n)
            !overflow_evt |-> $stable(segment_outputs);
    endproperty
    a_seg: assert property (p_seg) else $error("segments moved"); // R3
    property p_reload;
        @(posedge clock) disable iff (!rst_n)
            ovf |=> tmr_ff == ldm_pkg::RELOAD_VAL;
    endproperty
    a_reload: assert property (p_reload) else $error("no reload"); // R5
    property p_nomatch;
        @(posedge clock) disable iff (!rst_n)
            cmp_ff <= ldm_pkg::RELOAD_VAL |-> !match;
    endproperty
    a_nomatch: assert property (p_nomatch) else $error("match out of range"); // R14
    property p_cmp_in;
        @(posedge clock) disable iff (!rst_n)
            s_cmp |-> !overflow_evt && step_cnt_ff < STEP_CYC;
    endproperty
    a_cmp_in: assert property (p_cmp_in) else $error("compare outside step"); // R10
endmodule
`default_nettype wire

// *** design/ldm_pkg.sv ***
// shared constants for the led multiplex dimmer
package ldm_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned OSC_HZ = 6000000;
    localparam int unsigned OSC_DIV = 12;
    // machine cycle 2 us at 6 MHz / 12; tick count at the 40 MHz core clock
    localparam int unsigned TICK_NS = 2000;
    localparam int unsigned CLK_NS = 25;
    localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
    localparam int unsigned TICK_W = 7;
    localparam logic [15:0] RELOAD_VAL = 16'hff00;
    localparam logic [15:0] TMR_MAX = 16'hffff;
    localparam int unsigned NUM_POS = 4;
    localparam int unsigned SEG_W = 7;
    localparam int unsigned NUM_LEDS = 10;
    localparam int unsigned LIGHT_W = 4;
    localparam logic [1:0] POS_LAST = 2'h3;
    localparam logic [3:0] SEL_FIRST = 4'h1;
    localparam logic [3:0] SEL_NONE = 4'h0;
endpackage

// *** dv/ldm_disp_model.sv ***
// model of the multiplexed led display behind the drivers
`timescale 1ns/1ps
`default_nettype none
module ldm_disp_model (
    input wire logic clock,
    input wire logic [ldm_pkg::SEG_W-1:0] segment_outputs,
    input wire logic [ldm_pkg::NUM_POS-1:0] digit_select_outputs,
    output logic [3:0][6:0] shown,
    output logic multi_sel
);
    // -----------
    // digit latch
    // -----------
    // a lit digit glows with whatever the segment lines carry
    always @(posedge clock)
    begin
        for (int i = 0; i < 4; i++)
            if (digit_select_outputs[i] === 1'b1) shown[i] <= segment_outputs;
        if ($countones(digit_select_outputs) > 1) multi_sel <= 1'b1;
    end
    // two lit digits at once would ghost, so it is latched for the bench
    initial multi_sel = 1'b0;
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the led multiplex dimmer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic clock;
    logic rst_n;
    logic [3:0] digit0_seg;
    logic [6:0] digit1_seg;
    logic [6:0] digit2_seg;
    logic [9:0] led_on;
    logic [3:0] ambient_light;
    logic [6:0] segment_outputs;
    logic [3:0] digit_select_outputs;
    logic overflow_evt;
    logic compare_evt;
    logic [3:0][6:0] shown;
    logic multi_sel;
    int error_cnt = 0;
    int check_count = 0;
    int n;
    // --------
    // fixtures
    // --------
    ldm_mux_dimmer u_ldm_mux_dimmer (.clock, .rst_n, .digit0_seg, .digit1_seg, .digit2_seg,
        .led_on, .ambient_light, .segment_outputs, .digit_select_outputs, .overflow_evt,
        .compare_evt);
    ldm_disp_model u_ldm_disp_model (.clock, .segment_outputs, .digit_select_outputs,
        .shown, .multi_sel);
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // -----
    // tasks
    // -----
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // pattern each position should carry; spare lead lines hold leds 7-9
    function automatic logic [6:0] seg_exp(input int p);
        case (p)
            0: return {led_on[9:7], digit0_seg};
            1: return digit1_seg;
            2: return digit2_seg;
            default: return led_on[6:0];
        endcase
    endfunction
    // bounded so a dead timer cannot hang the run
    task automatic wait_ovf();
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end while (overflow_evt !== 1'b1 && n < 21000);
    endtask
    // one step: light ls, switched to lm at cycle 100; ec = compare tick, 0 = none
    task automatic run_step(input int p, input logic [3:0] ls, input logic [3:0] lm,
        input int ec);
        int c;
        logic bad;
        c = 0;
        bad = 1'b0;
        `CHK("sel", 4'(1 << p), digit_select_outputs)
        `CHK("seg", seg_exp(p), segment_outputs)
        ambient_light = ls;
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
            if (n == 100) ambient_light = lm;
            if (compare_evt === 1'b1) c = n;
            if (overflow_evt !== 1'b1 && segment_outputs !== seg_exp(p)) bad = 1'b1;
            if (overflow_evt !== 1'b1 && digit_select_outputs !== (c > 0 ? 4'h0 : 4'(1 << p)))
                bad = 1'b1;
        end while (overflow_evt !== 1'b1 && n < 21000);
        `CHK("period", 20480, n)
        `CHK("hold", 1'b0, bad)
        `CHK("cmp", 1'b1, ec > 0 ? c >= (ec - 1) * 80 && c <= (ec + 1) * 80 : c == 0)
        $display("step %0d done", p);
    endtask
    // --------
    // sequence
    // --------
    initial
    begin
        rst_n = 1'b0;
        digit0_seg = 4'h5;
        digit1_seg = 7'h2a;
        digit2_seg = 7'h13;
        led_on = 10'h2d6;
        ambient_light = 4'hf;
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        wait_ovf();
        `CHK("first", 1'b1, n >= 20480 && n <= 20560)
        run_step(0, 4'hf, 4'hf, 0);
        run_step(1, 4'hf, 4'h0, 16);
        run_step(2, 4'h7, 4'h7, 128);
        run_step(3, 4'he, 4'he, 240);
        `CHK("wrap", 4'h1, digit_select_outputs)
        `CHK("multi", 1'b0, multi_sel)
        `CHK("leds", led_on[6:0], shown[3])
        `CHK("digit2", digit2_seg, shown[2])
        conclude();
    end
    // five steps of 20480 cycles fit well inside this span
    initial
    begin
        #2750000;
        error_cnt++;
        conclude();
    end
endmodule
`default_nettype wire
